// [hw/pt_pkg.sv]
/*
 * constants shared by the period timer: register map, field layout,
 * reset values and the instruction-clock divide.
 * assumes a single clock domain and an 8-bit register port.
 */
//==============================================================
// Overview of operation
// RQ1: eight-bit counter, read and write by software, zero after any reset.
// RQ2: counter advances on instruction clock through prescale 1, 4 or 16.
// RQ3: counter counts up to period value, then wraps to zero next increment.
// RQ4: eight-bit period register, read and write, all ones after reset.
// RQ5: period matches feed four-bit postscaler whose output sets the match flag.
// RQ6: postscale field value plus one gives the postscale ratio.
// RQ7: run bit two enables counting; cleared, the counter stands still.
// RQ8: counter write, control write or reset clears both scaler counters.
// RQ9: control write leaves counter value unchanged.
// RQ10: raw period match pulse, before postscaler, goes to the serial port.
// RQ11: counter and match are exported as the PWM time base.
// RQ12: match flag at flags bit one, its enable at enables bit one.
// RQ13: prescale 00 divides by 1, 01 by 4, 1x by 16.
// RQ14: flag stays set until software clears it.
// RQ15: control bit seven reads zero; other control bits reset to zero.
`default_nettype none

package pt_pkg;

	//==========================================================
	// register map
	localparam logic [7:0] ADDR_INT_CTRL = 8'h0b;
	localparam logic [7:0] ADDR_FLAGS    = 8'h0c;
	localparam logic [7:0] ADDR_COUNT    = 8'h11;
	localparam logic [7:0] ADDR_CTRL     = 8'h12;
	localparam logic [7:0] ADDR_ENABLES  = 8'h8c;
	localparam logic [7:0] ADDR_PERIOD   = 8'h92;

	//==========================================================
	// reset values
	localparam logic [7:0] RST_COUNT    = 8'h00;
	localparam logic [7:0] RST_PERIOD   = 8'hff;
	localparam logic [7:0] RST_CTRL     = 8'h00;
	localparam logic [7:0] RST_INT_CTRL = 8'h00;

	//==========================================================
	// field layout
	localparam int unsigned CTRL_PRE_LSB   = 0;
	localparam int unsigned CTRL_RUN_BIT   = 2;
	localparam int unsigned CTRL_POST_LSB  = 3;
	localparam logic [7:0]  CTRL_IMPL_MASK = 8'h7f;
	localparam int unsigned FLAG_MATCH_BIT = 1;

	//==========================================================
	// scaler limits (ratio minus one)
	localparam logic [3:0] PRE_LIM_1  = 4'h0;
	localparam logic [3:0] PRE_LIM_4  = 4'h3;
	localparam logic [3:0] PRE_LIM_16 = 4'hf;

	// oscillator cycles per instruction cycle
	localparam int unsigned INSTR_DIV = 4;
	localparam logic [1:0]  INSTR_LIM = 2'(INSTR_DIV - 1);

	function automatic logic [3:0] pt_pre_limit(input logic [1:0] sel);
		case (sel)
			2'b00:   pt_pre_limit = PRE_LIM_1;
			2'b01:   pt_pre_limit = PRE_LIM_4;
			default: pt_pre_limit = PRE_LIM_16;
		endcase
	endfunction

endpackage

`default_nettype wire

// [hw/pt_scaler.sv]
/*
 * modulo counter used as divider: one pulse per (limit+1) ticks.
 * assumes clr and tick come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pt_scaler #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clr,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] limit,
	output var  logic [WIDTH-1:0] count,
	output logic                  pulse
);

	logic [WIDTH-1:0] next_count;

	// a clear masks the pulse so nothing downstream moves on that cycle
	assign pulse = tick && !clr && (count >= limit);

	always_comb begin
		next_count = count;
		if (clr)
			next_count = '0;
		else if (tick)
			next_count = (count >= limit) ? '0 : count + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			count <= '0;
		else
			count <= next_count;
	end

endmodule // pt_scaler

`default_nettype wire

// [hw/pt_timer.sv]
/*
 * eight-bit period timer with prescaler and postscaler, register
 * port, sticky match flag with enable and one level interrupt.
 * assumes mclk is the oscillator clock; arst_n may be asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none

module pt_timer
	import pt_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	output logic            irq,
	output var  logic       period_match,
	output var  logic [7:0] pwm_count,
	output var  logic [7:0] pwm_period
);

	//==========================================================
	// reset release
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	assign rst_n = rst_sync[1];

	//==========================================================
	// register strobes
	logic wr_count;
	logic wr_ctrl;
	logic wr_period;
	logic wr_flags;
	logic wr_enables;
	logic wr_int_ctrl;
	logic rd_flags;

	assign wr_count    = reg_wr && (reg_addr == ADDR_COUNT);
	assign wr_ctrl     = reg_wr && (reg_addr == ADDR_CTRL);
	assign wr_period   = reg_wr && (reg_addr == ADDR_PERIOD);
	assign wr_flags    = reg_wr && (reg_addr == ADDR_FLAGS);
	assign wr_enables  = reg_wr && (reg_addr == ADDR_ENABLES);
	assign wr_int_ctrl = reg_wr && (reg_addr == ADDR_INT_CTRL);
	assign rd_flags    = reg_rd && (reg_addr == ADDR_FLAGS);

	//==========================================================
	// control state
	logic [7:0] ctrl;
	logic [7:0] period;
	logic [7:0] int_ctrl;
	logic       flag;
	logic       enable;
	logic [7:0] next_ctrl;
	logic [7:0] next_period;
	logic [7:0] next_int_ctrl;
	logic       next_flag;
	logic       next_enable;
	logic [7:0] next_rdata;

	logic       run;
	logic [1:0] prescale_select;
	logic [3:0] postscale_select;

	assign run              = ctrl[CTRL_RUN_BIT];
	assign prescale_select  = ctrl[CTRL_PRE_LSB +: 2];
	assign postscale_select = ctrl[CTRL_POST_LSB +: 4];

	//==========================================================
	// scaler chain
	logic       instr_tick;
	logic [3:0] pre_cnt;
	logic [3:0] post_cnt;
	logic       count_en;
	logic       post_pulse;
	logic       scaler_clr;
	logic       wrap;
	logic [7:0] count;
	logic [7:0] next_count;
	logic       next_match;

	// counter and control writes restart both scalers
	assign scaler_clr = wr_count || wr_ctrl; // RQ8

	// instruction clock is the oscillator over four
	pt_scaler #(
		.WIDTH (2)
	) u_instr (
		.clk   (mclk),
		.rst_n (rst_n),
		.clr   (1'b0),
		.tick  (1'b1),
		.limit (INSTR_LIM),
		.count (),
		.pulse (instr_tick)
	);

	// gated by run so a stopped timer keeps its prescaler still
	pt_scaler #(
		.WIDTH (4)
	) u_pre (
		.clk   (mclk),
		.rst_n (rst_n),
		.clr   (scaler_clr),
		.tick  (instr_tick && run), // RQ2 RQ7
		.limit (pt_pre_limit(prescale_select)), // RQ13
		.count (pre_cnt),
		.pulse (count_en)
	);

	assign wrap = count_en && (count == period);

	pt_scaler #(
		.WIDTH (4)
	) u_post (
		.clk   (mclk),
		.rst_n (rst_n),
		.clr   (scaler_clr),
		.tick  (wrap), // RQ5
		.limit (postscale_select), // RQ6
		.count (post_cnt),
		.pulse (post_pulse)
	);

	//==========================================================
	// counter
	always_comb begin
		next_count = count;
		next_match = 1'b0;
		if (wr_count)
			next_count = reg_wdata; // RQ1
		else if (count_en) begin
			if (wrap) begin
				next_count = RST_COUNT; // RQ3
				next_match = 1'b1; // RQ10
			end else begin
				next_count = count + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count        <= RST_COUNT; // RQ1
			period_match <= 1'b0;
		end else begin
			count        <= next_count;
			period_match <= next_match;
		end
	end

	// PWM unit sees the live count and period
	assign pwm_count  = count; // RQ11
	assign pwm_period = period; // RQ11

	//==========================================================
	// registers and read port
	always_comb begin
		next_ctrl     = ctrl;
		next_period   = period;
		next_int_ctrl = int_ctrl;
		next_enable   = enable;
		next_flag     = flag;
		next_rdata    = 8'h00;
		if (wr_ctrl)
			next_ctrl = reg_wdata & CTRL_IMPL_MASK; // RQ15 RQ9
		if (wr_period)
			next_period = reg_wdata; // RQ4
		if (wr_int_ctrl)
			next_int_ctrl = reg_wdata;
		if (wr_enables)
			next_enable = reg_wdata[FLAG_MATCH_BIT]; // RQ12
		// a postscaled match beats a clear in the same cycle
		if (post_pulse)
			next_flag = 1'b1; // RQ5 RQ14
		else if (wr_flags)
			next_flag = reg_wdata[FLAG_MATCH_BIT]; // RQ12
		else if (rd_flags)
			next_flag = 1'b0;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_INT_CTRL: next_rdata = int_ctrl;
				ADDR_FLAGS:    next_rdata[FLAG_MATCH_BIT] = flag;
				ADDR_COUNT:    next_rdata = count;
				ADDR_CTRL:     next_rdata = ctrl;
				ADDR_ENABLES:  next_rdata[FLAG_MATCH_BIT] = enable;
				ADDR_PERIOD:   next_rdata = period;
				default:       next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl      <= RST_CTRL; // RQ15
			period    <= RST_PERIOD; // RQ4
			int_ctrl  <= RST_INT_CTRL;
			enable    <= 1'b0;
			flag      <= 1'b0;
			reg_rdata <= 8'h00;
		end else begin
			ctrl      <= next_ctrl;
			period    <= next_period;
			int_ctrl  <= next_int_ctrl;
			enable    <= next_enable;
			flag      <= next_flag;
			reg_rdata <= next_rdata;
		end
	end

	// level interrupt while the unmasked flag stands
	assign irq = flag && enable; // RQ12

	//==========================================================
	// checks
	property p_count_load;
		@(posedge mclk) disable iff (!rst_n)
		wr_count |=> (count == $past(reg_wdata));
	endproperty
	a_count_load: assert property (p_count_load) // RQ1
		else $error("counter did not take the written value");

	property p_count_wrap;
		@(posedge mclk) disable iff (!rst_n)
		(count_en && !wr_count && count == period)
			|=> (count == 8'h00) && period_match;
	endproperty
	a_count_wrap: assert property (p_count_wrap) // RQ3
		else $error("counter did not wrap to zero at period");

	property p_count_step;
		@(posedge mclk) disable iff (!rst_n)
		(count_en && !wr_count && count != period)
			|=> (count == $past(count) + 8'h01) && !period_match;
	endproperty
	a_count_step: assert property (p_count_step) // RQ3
		else $error("counter did not advance by one");

	property p_period_write;
		@(posedge mclk) disable iff (!rst_n)
		wr_period ##1 (reg_rd && reg_addr == ADDR_PERIOD)
			|=> (reg_rdata == $past(reg_wdata, 2));
	endproperty
	a_period_write: assert property (p_period_write) // RQ4
		else $error("period register read back wrong");

	property p_flag_set;
		@(posedge mclk) disable iff (!rst_n)
		post_pulse |=> flag ##1 (flag || $past(wr_flags || rd_flags));
	endproperty
	a_flag_set: assert property (p_flag_set) // RQ5
		else $error("postscaled match did not set the flag");

	property p_stopped;
		@(posedge mclk) disable iff (!rst_n)
		(!run && !wr_count) [*2] |-> $stable(count);
	endproperty
	a_stopped: assert property (p_stopped) // RQ7
		else $error("counter moved while stopped");

	property p_scaler_clear;
		@(posedge mclk) disable iff (!rst_n)
		scaler_clr |=> (pre_cnt == 4'h0) && (post_cnt == 4'h0);
	endproperty
	a_scaler_clear: assert property (p_scaler_clear) // RQ8
		else $error("scalers not cleared by write");

	property p_ctrl_keeps_count;
		@(posedge mclk) disable iff (!rst_n)
		wr_ctrl |=> (count == $past(count));
	endproperty
	a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) // RQ9
		else $error("control write changed the counter");

	property p_match_pulse;
		@(posedge mclk) disable iff (!rst_n)
		period_match |-> $past(wrap) ##1 !period_match;
	endproperty
	a_match_pulse: assert property (p_match_pulse) // RQ10
		else $error("match pulse without a wrap");

	property p_flag_holds;
		@(posedge mclk) disable iff (!rst_n)
		(flag && !wr_flags && !rd_flags) |=> flag;
	endproperty
	a_flag_holds: assert property (p_flag_holds) // RQ14
		else $error("flag dropped without software clear");

	property p_irq;
		@(posedge mclk) disable iff (!rst_n)
		(post_pulse && enable && !wr_enables) |=> irq;
	endproperty
	a_irq: assert property (p_irq) // RQ12
		else $error("interrupt output disagrees with flag and enable");

	property p_ctrl_bit7;
		@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_CTRL) |=> !reg_rdata[7];
	endproperty
	a_ctrl_bit7: assert property (p_ctrl_bit7) // RQ15
		else $error("control bit seven read as one");

	property p_pre_ratio;
		@(posedge mclk) disable iff (!rst_n)
		(count_en && prescale_select == 2'b01 && !scaler_clr && !wr_ctrl)
			|=> (!count_en || prescale_select != 2'b01) [*8];
	endproperty
	a_pre_ratio: assert property (p_pre_ratio) // RQ13
		else $error("prescale by four stepped too soon");

	// a set in the same cycle is allowed to win over the clear
	property p_flag_clear;
		@(posedge mclk) disable iff (!rst_n)
		(wr_flags && !reg_wdata[FLAG_MATCH_BIT] && !post_pulse) |=> !flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) // RQ14
		else $error("flag not cleared by a zero write");

	property p_enable_write;
		@(posedge mclk) disable iff (!rst_n)
		wr_enables |=> (enable == $past(reg_wdata[FLAG_MATCH_BIT]));
	endproperty
	a_enable_write: assert property (p_enable_write) // RQ12
		else $error("interrupt enable did not take the written bit");

	property p_run_gate;
		@(posedge mclk) disable iff (!rst_n)
		(!run && !scaler_clr) |=> (pre_cnt == $past(pre_cnt));
	endproperty
	a_run_gate: assert property (p_run_gate) // RQ7
		else $error("prescaler moved while stopped");

	property p_period_hold;
		@(posedge mclk) disable iff (!rst_n)
		!wr_period |=> (period == $past(period));
	endproperty
	a_period_hold: assert property (p_period_hold) // RQ4
		else $error("period register changed without a write");

endmodule // pt_timer

`default_nettype wire

// [verif/pt_timer_bench.sv]
/*
 * self-checking bench for pt_timer: register port, prescaler,
 * period wrap, postscaler, sticky flag and irq.
 * assumes pt_pkg is compiled first; the bench drives every port.
 */
`timescale 1ns/100ps
`default_nettype none

module pt_timer_bench
	import pt_pkg::*;
;
	logic       mclk;
	logic       arst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       irq;
	logic       period_match;
	logic [7:0] pwm_count;
	logic [7:0] pwm_period;
	int         n_mismatch;
	int         cmp_count;

	pt_timer uut (
		.mclk         (mclk),
		.arst_n       (arst_n),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.irq          (irq),
		.period_match (period_match),
		.pwm_count    (pwm_count),
		.pwm_period   (pwm_period)
	);

	initial mclk = 1'b0;
	always #4 mclk = ~mclk;

	//==========================================================
	// shared tasks
	task automatic test_done;
		$display("counts: %0d mismatches in %0d compares", n_mismatch,
			cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// step to the next edge and sample 1 ns after it, once settled
	task automatic cyc;
		@(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// write then read back with no idle cycle between the strobes
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] exp);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// cycles from one match pulse to the next, with the top count seen
	task automatic gap(output int n, output logic [7:0] mx);
		int i;
		n  = 0;
		mx = 8'h00;
		for (i = 0; i < 2000 && period_match !== 1'b1; i++)
			cyc();
		do begin
			cyc();
			n++;
			if (pwm_count > mx)
				mx = pwm_count;
		end while (period_match !== 1'b1 && n < 2000);
	endtask

	//==========================================================
	// scenarios
	task automatic t_reset;
		rdc(ADDR_COUNT, 8'h00);
		rdc(ADDR_PERIOD, 8'hff);
		rdc(ADDR_CTRL, 8'h00);
		rdc(ADDR_FLAGS, 8'h00);
		rdc(ADDR_ENABLES, 8'h00);
		rdc(8'h40, 8'h00);
		chk(pwm_period, 8'hff);
	endtask

	task automatic t_ctrl;
		wr(ADDR_CTRL, 8'hff);
		rdc(ADDR_CTRL, 8'h7f);
		wr(ADDR_INT_CTRL, 8'ha5);
		rdc(ADDR_INT_CTRL, 8'ha5);
		wr(8'h40, 8'h5a);
		rdc(8'h40, 8'h00);
		wr(ADDR_CTRL, 8'h00);
	endtask

	task automatic t_count;
		wr(ADDR_COUNT, 8'h37);
		rdc(ADDR_COUNT, 8'h37);
		wr(ADDR_CTRL, 8'h78);
		rdc(ADDR_COUNT, 8'h37);
		repeat (80) cyc();
		rdc(ADDR_COUNT, 8'h37);
	endtask

	task automatic t_pre;
		int n;
		int pre;
		logic [7:0] mx;
		wrrd(ADDR_PERIOD, 8'h02, 8'h02);
		wr(ADDR_COUNT, 8'h00);
		for (int s = 0; s < 4; s++) begin
			pre = (s == 0) ? 1 : (s == 1) ? 4 : 16;
			wr(ADDR_CTRL, 8'h04 | 8'(s));
			gap(n, mx);
			gap(n, mx);
			chk(8'(n), 8'(4 * pre * 3));
			chk(mx, 8'h02);
		end
		chk(pwm_period, 8'h02);
	endtask

	task automatic t_post;
		int n;
		int i;
		logic [3:0] ps [3] = '{4'h0, 4'h2, 4'hf};
		wr(ADDR_ENABLES, 8'h02);
		rdc(ADDR_ENABLES, 8'h02);
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_CTRL, {1'b0, ps[k], 3'b000});
			wr(ADDR_FLAGS, 8'h00);
			wr(ADDR_CTRL, {1'b0, ps[k], 3'b100});
			n = 0;
			for (i = 0; i < 400 && irq !== 1'b1; i++) begin
				cyc();
				if (period_match === 1'b1)
					n++;
			end
			chk(8'(n), 8'(ps[k]) + 8'h01);
		end
		repeat (20) cyc();
		chk(irq, 1'b1);
		wr(ADDR_ENABLES, 8'h00);
		cyc();
		chk(irq, 1'b0);
		rdc(ADDR_FLAGS, 8'h02);
		rdc(ADDR_FLAGS, 8'h00);
		wr(ADDR_FLAGS, 8'h02);
		rdc(ADDR_FLAGS, 8'h02);
		wr(ADDR_CTRL, 8'h00);
	endtask

	// a count write mid-prescale must restart the full divide by 16
	task automatic t_clr;
		int n;
		wr(ADDR_PERIOD, 8'hff);
		wr(ADDR_CTRL, 8'h06);
		repeat (40) cyc();
		wr(ADDR_COUNT, 8'h00);
		// let the written count settle before the first look
		#1;
		n = 0;
		while (pwm_count !== 8'h01 && n < 200) begin
			cyc();
			n++;
		end
		chk(8'(n >= 60 && n <= 66), 8'h01);
	endtask

	//==========================================================
	// main sequence and watchdog
	initial begin
		n_mismatch = 0;
		cmp_count  = 0;
		arst_n     = 1'b0;
		reg_addr   = 8'h00;
		reg_wdata  = 8'h00;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_ctrl();
		t_count();
		t_pre();
		t_post();
		t_clr();
		test_done();
	end

	// the whole run needs just under two thousand cycles
	initial begin
		#400000;
		n_mismatch++;
		test_done();
	end

endmodule // pt_timer_bench

`default_nettype wire
